// File: inc/dram_ctl_pkg.sv
// Shared constants, types and field layouts of the DRAM strobe controller.
// Assumes one 100 MHz clock (pclk) and an APB register slave in front.
// Functional notes
// - Forced refresh reuses row/column select as period clock, column strobe as generator clock.
// - Forced mode entered with period clock high acts as external refresh.
// - External low on request/reset pin clears the refresh counter.
// - Period clock falling without refresh in high phase drives request pin low.
// - With refresh select low in forced mode, counter drives address outputs.
// - Row strobes fall on second generator-clock fall, stay low two more falls.
// - Refresh request is released as the refresh row strobes fall.
// - Refresh select rising during low strobes ends refresh after fixed delay.
// - External access passes row strobe, column strobe and write straight through.
// - External access drives row latch while select high, column latch when low.
// - Column strobe held high while select high; auto-generated when input already low.
// - Later column strobe toggles are followed after an auto-generated strobe.
// - Mode bits: 00 ext refresh, 01 forced refresh, 10 ext access, 11 auto.
// - Refresh counter advances when row strobe input rises ending a refresh.
// - Nine-bit refresh counter counts to maximum and wraps to zero.
package dram_ctl_pkg;
   // Address and counter widths
   localparam int ADDR_W = 9;
   localparam int BANKS = 4;
   localparam int APB_AW = 12;
   // Register byte offsets
   localparam logic [APB_AW-1:0] CTRL_OFS = 12'h000;
   localparam logic [APB_AW-1:0] ROW_OFS = 12'h004;
   localparam logic [APB_AW-1:0] COL_OFS = 12'h008;
   localparam logic [APB_AW-1:0] STAT_OFS = 12'h00C;
   // Status field positions
   localparam int STAT_REQ_BIT = 9;
   localparam int STAT_LOW_BIT = 10;
   localparam int STAT_EXT_BIT = 11;
   // Mode codes {refresh_select_bit, mode_low_bit}
   localparam logic [1:0] MODE_EXT_REFRESH = 2'h0;
   localparam logic [1:0] MODE_FORCED = 2'h1;
   localparam logic [1:0] MODE_EXT_ACCESS = 2'h2;
   localparam logic [1:0] MODE_AUTO = 2'h3;
   // Timing: figures in ns, converted to pclk cycles
   localparam int CLK_PERIOD_NS = 10;
   localparam int EARLY_END_DELAY_NS = 30;
   localparam int COL_SETUP_DELAY_NS = 10;
   localparam int EARLY_END_CYC = (EARLY_END_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int COL_SETUP_CYC = (COL_SETUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Control register layout and reset value (auto access, bank 0)
   typedef struct packed {
      logic [1:0] bank;
      logic refresh_select_bit;
      logic mode_low_bit;
   } ctrl_t;
   localparam ctrl_t CTRL_RST = 4'h3;
   // DRAM-side outputs travel together
   typedef struct packed {
      logic [BANKS-1:0] row_strobe_n;
      logic col_strobe_n;
      logic write_en_n;
      logic [ADDR_W-1:0] addr;
   } dram_out_t;
   localparam dram_out_t DRAM_RST = 15'h7E00;
   // Forced refresh sequencer
   typedef enum logic [4:0] {
      F_IDLE = 5'b00001,
      F_WAIT = 5'b00010,
      F_LOW = 5'b00100,
      F_EARLY = 5'b01000,
      F_DONE = 5'b10000
   } fstate_t;
endpackage

// File: rtl/dram_strobe_ctl.sv
// DRAM address/strobe controller: external refresh, forced refresh, external access.
// Assumes asynchronous pins are synchronised here; registers sit on APB.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module dram_strobe_ctl
import dram_ctl_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic row_col_select,
   input wire logic row_strobe_in,
   input wire logic col_strobe_in,
   input wire logic write_in,
   input wire logic refresh_req_reset_pin_i,
   output logic refresh_req_reset_pin_o,
   output logic refresh_req_reset_pin_oe,
   output dram_out_t dram_r
);
   localparam int EARLY_MAX = EARLY_END_CYC + 2;
   localparam logic [ADDR_W-1:0] CNT_MAX = '1;

   ctrl_t ctrl_r;
   logic [ADDR_W-1:0] row_addr_r;
   logic [ADDR_W-1:0] col_addr_r;
   logic [ADDR_W-1:0] cnt;
   logic [4:0] sync_q;
   logic refresh_period_clock_s;
   logic row_s;
   logic col_s;
   logic write_s;
   logic pin_s;
   logic refresh_period_clock_d_r;
   logic row_d_r;
   logic col_d_r;
   logic [1:0] mode;
   logic [1:0] prev_mode_r;
   logic fr_ext_r;
   logic ext_now;
   logic refresh_ext;
   fstate_t fstate_r;
   fstate_t fstate_nxt;
   logic [1:0] falls_r;
   logic [3:0] early_r;
   logic sgc_fall;
   logic refresh_period_clock_fall;
   logic refresh_period_clock_rise;
   logic rc_fall;
   logic rf_low_nxt;
   logic forced_inc;
   logic ext_inc;
   logic cnt_inc;
   logic cnt_clr;
   logic refreshed_r;
   logic req_r;
   logic [2:0] req_hist_r;
   logic [3:0] acas_r;
   logic apb_setup;
   logic apb_wr;
   dram_out_t dram_nxt;
   logic [31:0] rdata_nxt;
   logic err_nxt;

   // Strobe low on the enabled bank only
   function automatic logic [BANKS-1:0] bank_enable(input logic [1:0] bank);
      bank_enable = '0;
      bank_enable[bank] = 1'b1;
   endfunction

   // Pins cross in from the outside world
   pin_sync #(.WIDTH(5), .RST_VAL(5'h1F)) u_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .d({row_col_select, row_strobe_in, col_strobe_in, write_in, refresh_req_reset_pin_i}),
      .q(sync_q)
   );
   assign refresh_period_clock_s = sync_q[4];
   assign row_s = sync_q[3];
   assign col_s = sync_q[2];
   assign write_s = sync_q[1];
   assign pin_s = sync_q[0];

   refresh_counter #(.WIDTH(ADDR_W)) u_cnt
   (
      .pclk(pclk),
      .presetn(presetn),
      .clr(cnt_clr),
      .inc(cnt_inc),
      .count_r(cnt)
   );

   // Edge history of synchronised pins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         refresh_period_clock_d_r <= 1'b1;
         row_d_r <= 1'b1;
         col_d_r <= 1'b1;
      end
      else
      begin
         refresh_period_clock_d_r <= refresh_period_clock_s;
         row_d_r <= row_s;
         col_d_r <= col_s;
      end
   end

   assign sgc_fall = col_d_r & ~col_s;
   assign refresh_period_clock_fall = refresh_period_clock_d_r & ~refresh_period_clock_s;
   assign refresh_period_clock_rise = ~refresh_period_clock_d_r & refresh_period_clock_s;
   assign rc_fall = refresh_period_clock_fall;
   assign mode = {ctrl_r.refresh_select_bit, ctrl_r.mode_low_bit};

   // Forced mode entered with period clock high behaves as external refresh
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prev_mode_r <= MODE_AUTO;
         fr_ext_r <= 1'b0;
      end
      else
      begin
         prev_mode_r <= mode;
         if (mode == MODE_FORCED && prev_mode_r != MODE_FORCED)
            fr_ext_r <= refresh_period_clock_s;
      end
   end
   assign ext_now = (prev_mode_r != MODE_FORCED) ? refresh_period_clock_s : fr_ext_r;
   assign refresh_ext = (mode == MODE_EXT_REFRESH) || (mode == MODE_FORCED && ext_now);

   // Forced refresh sequencer next state
   always_comb
   begin
      fstate_nxt = fstate_r;
      unique case (fstate_r)
         F_IDLE:
            if (mode == MODE_FORCED && !ext_now)
               fstate_nxt = F_WAIT;
         F_WAIT:
            if (mode != MODE_FORCED)
               fstate_nxt = F_IDLE;
            else if (sgc_fall && falls_r == 2'h1)
               fstate_nxt = F_LOW;
         F_LOW:
            if (mode != MODE_FORCED)
               fstate_nxt = F_EARLY;
            else if (sgc_fall && falls_r == 2'h1)
               fstate_nxt = F_DONE;
         F_EARLY:
            if (early_r == 4'h0)
               fstate_nxt = F_IDLE;
         F_DONE:
            if (mode != MODE_FORCED)
               fstate_nxt = F_IDLE;
         default:
            fstate_nxt = F_IDLE;
      endcase
   end
   assign rf_low_nxt = (fstate_nxt == F_LOW) || (fstate_nxt == F_EARLY);
   assign forced_inc = (fstate_r == F_LOW && fstate_nxt == F_DONE)
      || (fstate_r == F_EARLY && fstate_nxt == F_IDLE);
   assign ext_inc = refresh_ext && !row_d_r && row_s;
   assign cnt_inc = forced_inc | ext_inc;

   // Sequencer state, generator-clock fall count and early-end timer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fstate_r <= F_IDLE;
         falls_r <= 2'h0;
         early_r <= 4'h0;
      end
      else
      begin
         fstate_r <= fstate_nxt;
         if (fstate_nxt != fstate_r)
            falls_r <= 2'h0;
         else if (sgc_fall)
            falls_r <= falls_r + 2'h1;
         if (fstate_r == F_LOW && fstate_nxt == F_EARLY)
            early_r <= 4'(EARLY_END_CYC - 1);
         else if (early_r != 4'h0)
            early_r <= early_r - 4'h1;
      end
   end

   // Refresh seen during the high phase; set wins over the clear at the rise
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         refreshed_r <= 1'b0;
      else if (cnt_inc && refresh_period_clock_s)
         refreshed_r <= 1'b1;
      else if (refresh_period_clock_rise)
         refreshed_r <= 1'b0;
   end

   // Request on period clock fall; select toggles of a manual access never ask
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         req_r <= 1'b0;
      else if (refresh_period_clock_fall && !refreshed_r && mode != MODE_EXT_ACCESS)
         req_r <= 1'b1;
      else if ((rf_low_nxt && fstate_r == F_WAIT) || mode == MODE_EXT_REFRESH)
         req_r <= 1'b0;
   end

   // Own pull-down echoes back via output flop and synchroniser: three cycles late
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         req_hist_r <= 3'h0;
      else
         req_hist_r <= {req_hist_r[1:0], req_r};
   end
   assign cnt_clr = !pin_s && !req_r && req_hist_r == 3'h0;

   // Auto column strobe: hold off after select falls with strobe input low
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         acas_r <= 4'h0;
      else if (mode == MODE_EXT_ACCESS && rc_fall && !col_s)
         acas_r <= 4'(COL_SETUP_CYC);
      else if (acas_r != 4'h0)
         acas_r <= acas_r - 4'h1;
   end

   // DRAM output selection per mode
   always_comb
   begin
      dram_nxt = DRAM_RST;
      dram_nxt.write_en_n = write_s;
      if (rf_low_nxt)
      begin
         dram_nxt.row_strobe_n = '0;
         dram_nxt.addr = cnt;
      end
      else if (refresh_ext)
      begin
         dram_nxt.row_strobe_n = {BANKS{row_s}};
         dram_nxt.addr = cnt;
      end
      else
      begin
         unique case (mode)
            MODE_FORCED:
               dram_nxt.addr = cnt;
            MODE_EXT_ACCESS:
            begin
               dram_nxt.row_strobe_n = ~(bank_enable(ctrl_r.bank) & {BANKS{~row_s}});
               dram_nxt.addr = refresh_period_clock_s ? row_addr_r : col_addr_r;
               // Follows later toggles once the auto delay has run out
               dram_nxt.col_strobe_n = refresh_period_clock_s | rc_fall | (acas_r != 4'h0) | col_s;
            end
            MODE_AUTO:
               dram_nxt.addr = row_addr_r;
            default:
               dram_nxt.addr = cnt;
         endcase
      end
   end

   // All DRAM-facing outputs are registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dram_r <= DRAM_RST;
         refresh_req_reset_pin_o <= 1'b0;
         refresh_req_reset_pin_oe <= 1'b0;
      end
      else
      begin
         dram_r <= dram_nxt;
         refresh_req_reset_pin_o <= 1'b0;
         refresh_req_reset_pin_oe <= req_r;
      end
   end

   // APB: pready rises in the access phase, so no wait states
   assign apb_setup = psel && !penable && !pready;
   assign apb_wr = psel && penable && pready && pwrite;

   // Read mux and unmapped-address error
   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      err_nxt = 1'b0;
      unique case (paddr)
         CTRL_OFS:
            rdata_nxt[3:0] = ctrl_r;
         ROW_OFS:
            rdata_nxt[ADDR_W-1:0] = row_addr_r;
         COL_OFS:
            rdata_nxt[ADDR_W-1:0] = col_addr_r;
         STAT_OFS:
         begin
            rdata_nxt[ADDR_W-1:0] = cnt;
            rdata_nxt[STAT_REQ_BIT] = req_r;
            rdata_nxt[STAT_LOW_BIT] = (fstate_r == F_LOW) || (fstate_r == F_EARLY);
            rdata_nxt[STAT_EXT_BIT] = refresh_ext;
         end
         default:
            err_nxt = 1'b1;
      endcase
   end

   // Answer is prepared in the setup cycle and held through the access
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= apb_setup;
         if (apb_setup)
         begin
            prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
            pslverr <= err_nxt;
         end
         else if (!psel)
            pslverr <= 1'b0;
      end
   end

   // Register writes; status is read-only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r <= CTRL_RST;
         row_addr_r <= '0;
         col_addr_r <= '0;
      end
      else if (apb_wr)
      begin
         if (paddr == CTRL_OFS)
            ctrl_r <= pwdata[3:0];
         if (paddr == ROW_OFS)
            row_addr_r <= pwdata[ADDR_W-1:0];
         if (paddr == COL_OFS)
            col_addr_r <= pwdata[ADDR_W-1:0];
      end
   end

   // Checks on the logic above
   a_cas_rowsel_high: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == MODE_EXT_ACCESS && refresh_period_clock_s && !rf_low_nxt) |=> dram_r.col_strobe_n)
      else $error("column strobe low while row select high");

   a_addr_counter: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == MODE_FORCED && !cnt_inc && !cnt_clr) |=> dram_r.addr == cnt)
      else $error("address outputs not showing refresh counter");

   a_write_follow: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> dram_r.write_en_n == $past(write_s))
      else $error("write enable does not follow write input");

   a_ext_ras_follow: assert property (@(posedge pclk) disable iff (!presetn)
      (refresh_ext && !rf_low_nxt) |=> dram_r.row_strobe_n == {BANKS{$past(row_s)}})
      else $error("row strobes do not follow input in external refresh");

   a_req_on_fall: assert property (@(posedge pclk) disable iff (!presetn)
      (refresh_period_clock_fall && !refreshed_r && mode != MODE_EXT_ACCESS) |=> req_r ##1 refresh_req_reset_pin_oe)
      else $error("refresh request not raised on period clock fall");

   a_req_release: assert property (@(posedge pclk) disable iff (!presetn)
      (fstate_r == F_WAIT && fstate_nxt == F_LOW && !refresh_period_clock_fall) |=>
         (!req_r && dram_r.row_strobe_n == '0))
      else $error("request not released as refresh strobes fall");

   a_low_two_falls: assert property (@(posedge pclk) disable iff (!presetn)
      (fstate_r == F_LOW && mode == MODE_FORCED && sgc_fall && falls_r == 2'h1) |=>
         (dram_r.row_strobe_n == '1 && $past(dram_r.row_strobe_n) == '0))
      else $error("refresh strobes not released after two generator falls");

   a_early_end: assert property (@(posedge pclk) disable iff (!presetn)
      (fstate_r == F_LOW && mode != MODE_FORCED) |-> ##[1:EARLY_MAX] dram_r.row_strobe_n == '1)
      else $error("early refresh end did not release strobes in time");

   a_cnt_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      (cnt_inc && !cnt_clr && cnt == CNT_MAX) |=> cnt == '0)
      else $error("refresh counter did not wrap to zero at maximum");

   a_pin_reset: assert property (@(posedge pclk) disable iff (!presetn)
      cnt_clr |=> cnt == '0)
      else $error("external low on request pin did not clear counter");
endmodule

// File: rtl/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes each bit is an independent level; no bus coherence is implied.
`timescale 1ns/1ps
module pin_sync
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_r <= RST_VAL;
         q <= RST_VAL;
      end
      else
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// File: rtl/refresh_counter.sv
// Refresh row counter with synchronous clear and increment.
// Assumes clear and increment are single-cycle strobes on pclk.
`timescale 1ns/1ps
module refresh_counter
import dram_ctl_pkg::*;
#(
   parameter int WIDTH = ADDR_W
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clr,
   input wire logic inc,
   output logic [WIDTH-1:0] count_r
);
   // Clear wins; full binary wrap, never shortened for smaller arrays
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_r <= '0;
      else if (clr)
         count_r <= '0;
      else if (inc)
         count_r <= count_r + 1'b1;
   end
endmodule

// File: tb/dram_forced_refresh_and_manual_access_tb_top.sv
// Self-checking bench for the DRAM strobe controller: registers, manual access, refresh.
// Assumes the APB slave answers with pready and pins reach outputs a few edges later.
`timescale 1ns/1ps
module dram_forced_refresh_and_manual_access_tb_top;
   import dram_ctl_pkg::*;
   typedef struct {logic [APB_AW-1:0] a; logic [31:0] d; logic [31:0] e; logic err;} row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [APB_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic row_col_select, row_strobe_in, cas_drv, col_strobe_in, write_in;
   logic pin_o, pin_oe, wire_lvl, gen_clk, gen_run, pull_low;
   dram_out_t dram_r;
   int n_errors, n_tests, exp_cnt;
   // Write then read back; last row is an unmapped address
   row_t rows [5] = '{'{CTRL_OFS, 32'hA, 32'hA, 1'b0}, '{ROW_OFS, 32'h1A5, 32'h1A5, 1'b0},
      '{COL_OFS, 32'h5A, 32'h5A, 1'b0}, '{STAT_OFS, 32'hFFF, 32'h0, 1'b0},
      '{12'h010, 32'h1, 32'h0, 1'b1}};

   // Generator clock replaces the column strobe only during forced bursts
   assign col_strobe_in = gen_run ? gen_clk : cas_drv;

   dram_strobe_ctl u_dram_strobe_ctl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .row_col_select, .row_strobe_in, .col_strobe_in,
      .write_in, .refresh_req_reset_pin_i(wire_lvl), .refresh_req_reset_pin_o(pin_o),
      .refresh_req_reset_pin_oe(pin_oe), .dram_r(dram_r));

   sys_side_model u_sys_side_model (.pclk, .presetn, .gen_run, .pull_low, .dev_oe(pin_oe),
      .dev_o(pin_o), .gen_clk, .wire_lvl);

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic [APB_AW-1:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // Generator falls come from a flop on pclk and land on pclk edges; callers settle afterwards
   task automatic falls(input int n);
      repeat (n) @(negedge gen_clk);
   endtask

   task automatic rs_pulse();
      row_strobe_in <= 1'b0;
      settle(5);
      row_strobe_in <= 1'b1;
      settle(5);
   endtask

   task automatic stop_test();
      if (n_errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Hang guard, well above the roughly 5400 cycles the sequence needs
   initial
   begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      stop_test();
   end

   initial
   begin
      {presetn, psel, penable, pwrite, gen_run, pull_low} = 6'h00;
      {row_col_select, row_strobe_in, cas_drv, write_in} = 4'hF;
      paddr = '0;
      pwdata = '0;
      n_errors = 0;
      n_tests = 0;
      exp_cnt = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk(dram_r, DRAM_RST);
      chk(pin_oe, 1'b0);
      foreach (rows[i])
      begin
         apb(rows[i].a, 1'b1, rows[i].d);
         apb(rows[i].a, 1'b0, 32'h0);
         chk(rd, rows[i].e);
         chk(er, rows[i].err);
      end
      // Manual access on bank 2 with the column strobe input already low
      settle(6);
      chk(dram_r.addr, 9'h1A5);
      row_strobe_in <= 1'b0;
      cas_drv <= 1'b0;
      write_in <= 1'b0;
      settle(6);
      chk(dram_r.row_strobe_n, 4'hB);
      chk(dram_r.col_strobe_n, 1'b1);
      chk(dram_r.write_en_n, 1'b0);
      row_col_select <= 1'b0;
      settle(8);
      chk(dram_r.addr, 9'h05A);
      chk(dram_r.col_strobe_n, 1'b0);
      cas_drv <= 1'b1;
      settle(6);
      chk(dram_r.col_strobe_n, 1'b1);
      cas_drv <= 1'b0;
      settle(6);
      chk(dram_r.col_strobe_n, 1'b0);
      {row_col_select, row_strobe_in, cas_drv, write_in} <= 4'hF;
      settle(6);
      chk(dram_r.write_en_n, 1'b1);
      // Forced mode entered with the period clock high behaves as external refresh
      apb(CTRL_OFS, 1'b1, 32'h1);
      row_strobe_in <= 1'b0;
      settle(6);
      chk(dram_r.row_strobe_n, 4'h0);
      chk(dram_r.addr, 9'h000);
      apb(STAT_OFS, 1'b0, 32'h0);
      chk(rd[11:9], 3'h4);
      row_strobe_in <= 1'b1;
      settle(6);
      exp_cnt = 1;
      // Period clock falls: no request after a refreshed high phase, one after an idle one
      apb(CTRL_OFS, 1'b1, 32'h3);
      row_col_select <= 1'b0;
      settle(6);
      chk(pin_oe, 1'b0);
      row_col_select <= 1'b1;
      settle(6);
      row_col_select <= 1'b0;
      settle(6);
      chk(wire_lvl, 1'b0);
      chk(pin_o, 1'b0);
      apb(STAT_OFS, 1'b0, 32'h0);
      chk(rd[11:9], 3'h1);
      // Full forced refresh driven by generator clock falls
      apb(CTRL_OFS, 1'b1, 32'h1);
      gen_run <= 1'b1;
      falls(1);
      settle(3);
      chk(dram_r.row_strobe_n, 4'hF);
      falls(1);
      settle(7);
      chk(dram_r.row_strobe_n, 4'h0);
      chk(pin_oe, 1'b0);
      chk(dram_r.addr, 9'(exp_cnt));
      apb(STAT_OFS, 1'b0, 32'h0);
      chk(rd[11:9], 3'h2);
      falls(2);
      settle(7);
      chk(dram_r.row_strobe_n, 4'hF);
      gen_run <= 1'b0;
      exp_cnt++;
      // Second refresh cut short by leaving forced mode while strobes are low
      apb(CTRL_OFS, 1'b1, 32'h3);
      apb(CTRL_OFS, 1'b1, 32'h1);
      gen_run <= 1'b1;
      falls(2);
      settle(7);
      chk(dram_r.row_strobe_n, 4'h0);
      apb(CTRL_OFS, 1'b1, 32'h3);
      settle(8);
      chk(dram_r.row_strobe_n, 4'hF);
      gen_run <= 1'b0;
      exp_cnt++;
      apb(STAT_OFS, 1'b0, 32'h0);
      chk(rd[8:0], 9'(exp_cnt));
      // Counter cleared by an outside sink on the shared wire
      pull_low <= 1'b1;
      settle(8);
      pull_low <= 1'b0;
      settle(4);
      apb(STAT_OFS, 1'b0, 32'h0);
      chk(rd[8:0], 9'h000);
      // Burst refresh to the top of the count, then across the wrap
      apb(CTRL_OFS, 1'b1, 32'h0);
      repeat (511) rs_pulse();
      apb(STAT_OFS, 1'b0, 32'h0);
      chk(rd[8:0], 9'h1FF);
      row_strobe_in <= 1'b0;
      settle(6);
      chk(dram_r.row_strobe_n, 4'h0);
      chk(dram_r.addr, 9'h1FF);
      row_strobe_in <= 1'b1;
      settle(6);
      apb(STAT_OFS, 1'b0, 32'h0);
      chk(rd[8:0], 9'h000);
      stop_test();
   end
endmodule

// File: tb/sys_side_model.sv
// System-side partner: generator clock source and the open-drain request/reset wire.
// Assumes pclk is the only time base; the bench commands clock bursts and counter resets.
`timescale 1ns/1ps
module sys_side_model
#(
   parameter int HALF = 6
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic gen_run,
   input wire logic pull_low,
   input wire logic dev_oe,
   input wire logic dev_o,
   output logic gen_clk,
   output logic wire_lvl
);
   logic [3:0] half_cnt_r;

   // Generator clock runs only during a commanded burst, idles high otherwise
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         half_cnt_r <= 4'h0;
         gen_clk <= 1'b1;
      end
      else if (!gen_run)
      begin
         half_cnt_r <= 4'h0;
         gen_clk <= 1'b1;
      end
      else if (half_cnt_r == 4'(HALF - 1))
      begin
         half_cnt_r <= 4'h0;
         gen_clk <= ~gen_clk;
      end
      else
      begin
         half_cnt_r <= half_cnt_r + 4'h1;
      end
   end

   // Pulled-up wire: both parties may only sink it, never drive it high
   assign wire_lvl = ~((dev_oe & ~dev_o) | pull_low);
endmodule
